// ---- meas_setup_params.svh ----
// offsets, field positions, reset values and timing constants for the
// channel setup block; assumes inclusion by bare name.
`ifndef MEAS_SETUP_PARAMS_SVH
`define MEAS_SETUP_PARAMS_SVH
// ------------------------------------------------------------------
// register addresses on the serial register port
// ------------------------------------------------------------------
`define ADDR_CHAN_A      4'h1
`define ADDR_CHAN_B      4'h2
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define VCAL_MSB         16
`define VCAL_LSB         14
`define PATH_MSB         13
`define PATH_LSB         9
`define GAIN_MSB         8
`define GAIN_LSB         7
`define OSF_BIT          6
`define OSR_BIT          5
`define CHOP_BIT         4
`define AVG_MSB          3
`define AVG_LSB          0
// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define CHAN_A_RESET     17'h003c0
`define CHAN_B_RESET     17'h018c0
// ------------------------------------------------------------------
// constants
// ------------------------------------------------------------------
`define CAL_FIXED        11'h60c
`define AVG_RAW          4'hf
`define AVG_MAX          4'ha
`define RATE_LO_KHZ      2048
`define RATE_HI_KHZ      4096
`define DEC_LO           8'h40
`define DEC_HI           8'h80
`define CHOP_LO          4'h4
`define CHOP_HI          4'h8
`define CHOP_OFF         4'h1
`define RAW_SHIFT_LO     5'h0e
`define RAW_SHIFT_HI     5'h11
`endif

// ---- meas_setup_pkg.sv ----
// types for the channel setup block; no assumptions on surroundings.
package meas_setup_pkg;
	typedef struct packed {
		logic [2:0] voltage_cal_select;
		logic       unity_gain_switch;
		logic       voltage_bus_switch;
		logic       low_ref_switch;
		logic       temp_path_switch;
		logic       shunt_path_switch;
		logic [1:0] amp_gain_field;
		logic       oversample_rate_bit;
		logic       decimation_ratio_bit;
		logic       chop_ratio_bit;
		logic [3:0] averaging_code;
	} chan_setup_s;

	typedef struct packed {
		logic [10:0] cal_const;
		logic [6:0]  gain;
		logic [7:0]  decim_ratio;
		logic [3:0]  chop_ratio;
		logic        fast_rate;
		logic [10:0] avg_count;
		logic        raw_mode;
		logic        test_code;
		logic        bad_path;
		logic [4:0]  raw_shift;
	} conv_setup_s;

	typedef struct packed {
		chan_setup_s chan_a_q;
		chan_setup_s chan_b_q;
		conv_setup_s active_q;
	} setup_state_s;
endpackage

// ---- meas_setup.sv ----
// channel a/b setup registers and decode for the conversion logic.
// assumes a serial front end delivering decoded 17-bit writes and
// a converter that pulses conv_start_in on the device clock.
`timescale 1ns/1ns
`include "meas_setup_params.svh"
module meas_setup (
	input  wire logic                       clk_in,
	input  wire logic                       rstn_in,
	input  wire logic                       wr_en_in,
	input  wire logic [3:0]                 wr_addr_in,
	input  wire logic [16:0]                wr_data_in,
	input  wire logic [3:0]                 rd_addr_in,
	output logic [16:0]                     rd_data_out,
	input  wire logic                       conv_start_in,
	input  wire logic                       chan_b_sel_in,
	input  wire logic                       chop_en_in,
	input  wire logic                       dechop_en_in,
	input  wire logic [109:0]               cal_table_in,
	output meas_setup_pkg::chan_setup_s     path_out,
	output meas_setup_pkg::conv_setup_s     conv_out
);
	import meas_setup_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	setup_state_s s_q;
	setup_state_s s_d;
	chan_setup_s  sel;
	conv_setup_s  dec;
	logic [4:0]   path;

	// constants packed high to low: current 0..3, then voltage 0..5
	function automatic logic [10:0] cal_word(input logic [3:0] idx);
		logic [6:0] lo;
		lo = 7'(11 * (9 - idx));
		return cal_table_in[lo +: 11];
	endfunction

	// ------------------------------------------------------------------
	// decode of the selected channel
	// ------------------------------------------------------------------
	always_comb
	begin
		sel = chan_b_sel_in ? s_q.chan_b_q : s_q.chan_a_q;
		path = {sel.unity_gain_switch, sel.voltage_bus_switch,
			sel.low_ref_switch, sel.temp_path_switch,
			sel.shunt_path_switch};
		dec = '0;
		if (sel.shunt_path_switch)
			dec.cal_const = cal_word({2'b00, sel.amp_gain_field});
		else if (sel.voltage_cal_select > 3'h5)
			dec.cal_const = `CAL_FIXED;
		else
			dec.cal_const = cal_word(4'(sel.voltage_cal_select) + 4'h4);
		unique case (sel.amp_gain_field)
			2'h0: dec.gain = 7'h06;
			2'h1: dec.gain = 7'h18;
			2'h2: dec.gain = 7'h32;
			2'h3: dec.gain = 7'h64;
		endcase
		if (sel.unity_gain_switch)
			dec.gain = 7'h01;
		dec.fast_rate = sel.oversample_rate_bit;
		dec.decim_ratio = sel.decimation_ratio_bit ? `DEC_HI : `DEC_LO;
		// with both chop stages off the ratio bit has no meaning
		if (!chop_en_in && !dechop_en_in)
			dec.chop_ratio = `CHOP_OFF;
		else
			dec.chop_ratio = sel.chop_ratio_bit ? `CHOP_HI : `CHOP_LO;
		dec.raw_mode = (sel.averaging_code == `AVG_RAW);
		dec.test_code = !dec.raw_mode && sel.averaging_code > `AVG_MAX;
		// reserved codes fall back to one sample rather than overflow
		if (sel.averaging_code <= `AVG_MAX)
			dec.avg_count = 11'h001 << sel.averaging_code;
		else
			dec.avg_count = 11'h001;
		dec.raw_shift = sel.decimation_ratio_bit ? `RAW_SHIFT_HI
			: `RAW_SHIFT_LO;
		unique case (path)
			5'h01, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14:
				dec.bad_path = 1'b0;
			default: dec.bad_path = 1'b1;
		endcase
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (wr_en_in && wr_addr_in == `ADDR_CHAN_A)
			s_d.chan_a_q = chan_setup_s'(wr_data_in);
		if (wr_en_in && wr_addr_in == `ADDR_CHAN_B)
			s_d.chan_b_q = chan_setup_s'(wr_data_in);
		if (conv_start_in)
			s_d.active_q = dec;
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_q.chan_a_q <= chan_setup_s'(`CHAN_A_RESET);
			s_q.chan_b_q <= chan_setup_s'(`CHAN_B_RESET);
			s_q.active_q <= '0;
		end
		else
			s_q <= s_d;
	end

	always_comb
	begin
		unique case (rd_addr_in)
			`ADDR_CHAN_A: rd_data_out = 17'(s_q.chan_a_q);
			`ADDR_CHAN_B: rd_data_out = 17'(s_q.chan_b_q);
			default:      rd_data_out = 17'h00000;
		endcase
	end

	assign path_out = chan_b_sel_in ? s_q.chan_b_q : s_q.chan_a_q;
	assign conv_out = s_q.active_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_write_a;
		@(posedge clk_in) disable iff (!rstn_in)
		wr_en_in && wr_addr_in == `ADDR_CHAN_A
			|=> 17'(s_q.chan_a_q) == $past(wr_data_in);
	endproperty
	a_write_a: assert property (p_write_a)
		else $error("channel a write lost");

	property p_hold_b;
		@(posedge clk_in) disable iff (!rstn_in)
		!(wr_en_in && wr_addr_in == `ADDR_CHAN_B) |=> $stable(s_q.chan_b_q);
	endproperty
	a_hold_b: assert property (p_hold_b)
		else $error("channel b changed without write");

	property p_gain;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && !sel.unity_gain_switch && sel.amp_gain_field == 2'h2
			|=> conv_out.gain == 7'h32;
	endproperty
	a_gain: assert property (p_gain)
		else $error("gain decode wrong");

	property p_fixed_cal;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && !sel.shunt_path_switch
			&& sel.voltage_cal_select[2:1] == 2'h3
			|=> conv_out.cal_const == `CAL_FIXED;
	endproperty
	a_fixed_cal: assert property (p_fixed_cal)
		else $error("fixed constant not used");

	property p_decim;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in |=> conv_out.decim_ratio ==
			($past(sel.decimation_ratio_bit) ? `DEC_HI : `DEC_LO);
	endproperty
	a_decim: assert property (p_decim)
		else $error("decimation ratio wrong");

	property p_chop_off;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && !chop_en_in && !dechop_en_in
			|=> conv_out.chop_ratio == `CHOP_OFF;
	endproperty
	a_chop_off: assert property (p_chop_off)
		else $error("chop not bypassed");

	property p_chop;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && chop_en_in && sel.chop_ratio_bit
			|=> conv_out.chop_ratio == `CHOP_HI;
	endproperty
	a_chop: assert property (p_chop)
		else $error("chop ratio wrong");

	property p_raw;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in |=> conv_out.raw_mode ==
			($past(sel.averaging_code) == `AVG_RAW);
	endproperty
	a_raw: assert property (p_raw)
		else $error("raw mode decode wrong");

	property p_avg;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && sel.averaging_code == `AVG_MAX
			|=> conv_out.avg_count == 11'h400;
	endproperty
	a_avg: assert property (p_avg)
		else $error("averaging depth wrong");

	property p_shunt_cal;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && sel.shunt_path_switch && sel.amp_gain_field == 2'h0
			|=> conv_out.cal_const == $past(cal_table_in[109:99]);
	endproperty
	a_shunt_cal: assert property (p_shunt_cal)
		else $error("current constant not used");

	property p_raw_shift;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && sel.decimation_ratio_bit
			|=> conv_out.raw_shift == 5'h11;
	endproperty
	a_raw_shift: assert property (p_raw_shift)
		else $error("raw scale exponent wrong");

	property p_rate;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in |=> conv_out.fast_rate == $past(sel.oversample_rate_bit);
	endproperty
	a_rate: assert property (p_rate)
		else $error("rate bit not carried");

	property p_write_b;
		@(posedge clk_in) disable iff (!rstn_in)
		wr_en_in && wr_addr_in == `ADDR_CHAN_B
			|=> 17'(s_q.chan_b_q) == $past(wr_data_in);
	endproperty
	a_write_b: assert property (p_write_b)
		else $error("channel b write lost");

	property p_hold_a;
		@(posedge clk_in) disable iff (!rstn_in)
		!(wr_en_in && wr_addr_in == `ADDR_CHAN_A) |=> $stable(s_q.chan_a_q);
	endproperty
	a_hold_a: assert property (p_hold_a)
		else $error("channel a changed without write");

	// decode only moves on a start, so a mid-conversion write is safe
	property p_hold_conv;
		@(posedge clk_in) disable iff (!rstn_in)
		!conv_start_in |=> $stable(conv_out);
	endproperty
	a_hold_conv: assert property (p_hold_conv)
		else $error("decode changed without start");

	property p_unity;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && sel.unity_gain_switch
			|=> conv_out.gain == 7'h01;
	endproperty
	a_unity: assert property (p_unity)
		else $error("unity gain path not applied");

	property p_bad_path;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in |=> conv_out.bad_path == !($past(path) inside
			{5'h01, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14});
	endproperty
	a_bad_path: assert property (p_bad_path)
		else $error("path legality flag wrong");

	property p_avg_min;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && sel.averaging_code == 4'h0
			|=> conv_out.avg_count == 11'h001;
	endproperty
	a_avg_min: assert property (p_avg_min)
		else $error("single sample depth wrong");

	property p_volt_cal;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && !sel.shunt_path_switch
			&& sel.voltage_cal_select == 3'h0
			|=> conv_out.cal_const == $past(cal_table_in[65:55]);
	endproperty
	a_volt_cal: assert property (p_volt_cal)
		else $error("voltage constant 0 not used");

	property p_chop_lo;
		@(posedge clk_in) disable iff (!rstn_in)
		conv_start_in && chop_en_in && !sel.chop_ratio_bit
			|=> conv_out.chop_ratio == `CHOP_LO;
	endproperty
	a_chop_lo: assert property (p_chop_lo)
		else $error("low chop ratio wrong");

	// ------------------------------------------------------------------
	// write followed later by a start on channel a
	// ------------------------------------------------------------------
	sequence s_load_a;
		wr_en_in && wr_addr_in == `ADDR_CHAN_A;
	endsequence

	sequence s_quiet_a;
		!(wr_en_in && wr_addr_in == `ADDR_CHAN_A);
	endsequence

	sequence s_start_a;
		conv_start_in && !chan_b_sel_in;
	endsequence

	// a start in the write cycle itself would still see the old word
	property p_load_start;
		@(posedge clk_in) disable iff (!rstn_in)
		s_load_a ##1 s_quiet_a [*2] ##1 s_start_a
			|=> conv_out.raw_mode ==
			($past(wr_data_in[3:0], 4) == `AVG_RAW);
	endproperty
	a_load_start: assert property (p_load_start)
		else $error("written word not used at start");
endmodule

// ---- setup_host.sv ----
// host model: turns bench requests into one-cycle setup writes.
// assumes requests last one cycle with a free cycle between them.
`timescale 1ns/1ns
module setup_host (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        req_in,
	input  wire logic        legal_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [16:0] data_in,
	output logic             wr_en_out,
	output logic [3:0]       wr_addr_out,
	output logic [16:0]      wr_data_out
);
	// ------------------------------------------------------------
	// word shaping
	// ------------------------------------------------------------
	// legal_in low lets a scenario send illegal paths and test codes
	localparam logic [4:0] pats [8] = '{5'h01, 5'h08, 5'h0a, 5'h0c,
		5'h10, 5'h12, 5'h14, 5'h08};
	logic [16:0] w;
	always_comb
	begin
		w = data_in;
		if (legal_in)
			w[13:9] = pats[data_in[11:9] | {2'h0, addr_in[1]}];
		if (legal_in && w[3:0] > 4'ha && w[3:0] != 4'hf)
			w[3:0] = 4'hf;
		if (addr_in == 4'h2)
			w[9] = 1'b0;
	end
	// ------------------------------------------------------------
	// write port
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in)
		if (!rstn_in)
			wr_en_out <= 1'b0;
		else
			wr_en_out <= req_in;
	// data turns over when idle, so a stale word is never taken
	always_ff @(posedge clk_in)
		if (req_in)
		begin
			wr_addr_out <= addr_in;
			wr_data_out <= w;
		end
		else
			wr_data_out <= ~wr_data_out;
endmodule

// ---- meas_setup_tb.sv ----
// self-checking bench for the channel setup block.
// assumes setup_host as the writer and a 250 MHz device clock.
`timescale 1ns/1ns
module meas_setup_tb;
	import meas_setup_pkg::*;
	logic         clk_in = 1'b0;
	logic         rstn_in;
	logic         req = 1'b0;
	logic         lg = 1'b1;
	logic [3:0]   addr = 4'h0;
	logic [16:0]  data = 17'h00000;
	logic         wr_en;
	logic [3:0]   wr_addr;
	logic [16:0]  wr_data;
	logic [3:0]   rd_addr = 4'h0;
	logic [16:0]  rd_data;
	logic         conv_st = 1'b0;
	logic         chb = 1'b0;
	logic [1:0]   cd = 2'h3;
	logic [109:0] cal = '0;
	chan_setup_s  path;
	conv_setup_s  conv;
	conv_setup_s  xc = '0;
	logic [16:0]  ea = 17'h003c0;
	logic [16:0]  eb = 17'h018c0;
	logic [31:0]  seed = 32'h00000023;
	logic [31:0]  r = 32'h00000000;
	int           n_mismatch = 0;
	int           compares = 0;
	always #2 clk_in = ~clk_in;
	setup_host setup_host_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.req_in(req), .legal_in(lg), .addr_in(addr), .data_in(data),
		.wr_en_out(wr_en), .wr_addr_out(wr_addr), .wr_data_out(wr_data));
	meas_setup meas_setup_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
		.rd_addr_in(rd_addr), .rd_data_out(rd_data),
		.conv_start_in(conv_st), .chan_b_sel_in(chb),
		.chop_en_in(cd[0]), .dechop_en_in(cd[1]), .cal_table_in(cal),
		.path_out(path), .conv_out(conv));
	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	always @(posedge clk_in)
		if (wr_en && wr_addr == 4'h1)
			ea <= wr_data;
		else if (wr_en && wr_addr == 4'h2)
			eb <= wr_data;
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic conv_setup_s dec(input logic [16:0] w);
		int g[4] = '{6, 24, 50, 100};
		int n = w[3:0];
		int i = w[9] ? w[8:7] : 4 + w[16:14];
		conv_setup_s c;
		c.cal_const = i > 9 ? 11'h60c : cal[109 - 11 * i -: 11];
		c.gain = w[13] ? 7'h01 : 7'(g[w[8:7]]);
		c.decim_ratio = w[5] ? 8'h80 : 8'h40;
		c.chop_ratio = cd == 2'h0 ? 4'h1 : w[4] ? 4'h8 : 4'h4;
		c.fast_rate = w[6];
		c.avg_count = n < 11 ? 11'(1 << n) : 11'h001;
		c.raw_mode = n == 15;
		c.test_code = n > 10 && n < 15;
		c.bad_path = !(w[13:9] inside {5'h01, 5'h08, 5'h0a, 5'h0c,
			5'h10, 5'h12, 5'h14});
		c.raw_shift = w[5] ? 5'h11 : 5'h0e;
		return c;
	endfunction
	// ------------------------------------------------------------
	// drivers and checks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write and start land on the same edge: start must see old word
	task automatic cycle(input bit w, input bit s, input bit l,
		input logic [3:0] a, input logic [16:0] d, input bit b);
		@(posedge clk_in);
		req <= w;
		lg <= l;
		addr <= a;
		data <= d;
		@(posedge clk_in);
		req <= 1'b0;
		conv_st <= s;
		chb <= b;
		cd <= r[1:0];
		rd_addr <= a;
		@(posedge clk_in);
		conv_st <= 1'b0;
		if (s)
			xc = dec(b ? eb : ea);
		@(negedge clk_in);
		chk("read", a == 4'h1 ? ea : a == 4'h2 ? eb : 17'h0,
			rd_data);
		chk("path", b ? eb : ea, path);
		chk("cal", xc.cal_const, conv.cal_const);
		chk("decode", xc, conv);
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		rstn_in <= 1'b0;
		cal = 110'({rnd(), rnd(), rnd(), rnd()});
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		cycle(0, 1, 1, 4'h1, 17'h0, 0);
		cycle(0, 1, 1, 4'h2, 17'h0, 1);
		cycle(1, 0, 1, 4'h3, 17'h1ffff, 0);
		for (int k = 0; k < 16; k++)
		begin
			r = rnd();
			cycle(1, 1, 0, 4'h1, {3'(k), r[9:0], 4'(k)}, 0);
		end
		for (int k = 0; k < 48; k++)
		begin
			r = rnd();
			cycle(1, r[31], r[30], {3'h0, r[29]} + 4'h1, r[16:0], r[28]);
		end
		summarize();
	end
	initial
	begin
		#(4 * 2000);
		n_mismatch++;
		summarize();
	end
endmodule
